// File: hdl/dmd_regs.vh
`ifndef DMD_REGS_VH
`define DMD_REGS_VH

// ****************************************************************
// APB register byte offsets
// ****************************************************************
`define DMD_OFS_CTRL        8'h00
`define DMD_OFS_STATUS      8'h04
`define DMD_OFS_HW_SEC      8'h08
`define DMD_OFS_BOOT_VEC    8'h0c
`define DMD_OFS_SW_SEC      8'h10
`define DMD_OFS_CMD         8'h14

// ****************************************************************
// Control register fields
// ****************************************************************
`define DMD_CTRL_BANK_LO    0
`define DMD_CTRL_BANK_HI    1
`define DMD_CTRL_OFFCHIP    2
`define DMD_CTRL_SIZE_LO    3
`define DMD_CTRL_SIZE_HI    4
`define DMD_CTRL_X2         5
`define DMD_CTRL_RESET      8'h00

// ****************************************************************
// Status and command fields
// ****************************************************************
`define DMD_STAT_X2         0
`define DMD_STAT_BOOTLDR    1
`define DMD_STAT_HWMODE     2
`define DMD_STAT_BUSY       3
`define DMD_CMD_ERASE       0

// ****************************************************************
// Hardware security byte layout
// ****************************************************************
`define DMD_HSB_X2B         7
`define DMD_HSB_BOOT_JUMP_CFG        6
`define DMD_HSB_RSVD_MASK   8'h38
`define DMD_HSB_LOCK_MASK   8'h07
`define DMD_HSB_SW_MASK     8'hc0
`define DMD_NV_ERASED       8'hff

// ****************************************************************
// Memory map
// ****************************************************************
`define DMD_LOWER_TOP       8'h7f
`define DMD_BITRAM_BASE     8'h20
`define DMD_LIM_256         16'h00ff
`define DMD_LIM_512         16'h01ff
`define DMD_LIM_1K          16'h03ff
`define DMD_LIM_2K          16'h07ff
`define DMD_VEC_BOOT        16'hf000
`define DMD_VEC_USER        16'h0000

// ****************************************************************
// Access modes
// ****************************************************************
`define DMD_MODE_DIRECT     2'h0
`define DMD_MODE_INDIRECT   2'h1
`define DMD_MODE_REGISTER   2'h2
`define DMD_MODE_BIT        2'h3

`endif

// File: hdl/dmd_hw_bytes.v
`include "dmd_regs.vh"
`default_nettype none

// Nonvolatile configuration bytes, modelled as flops preloaded at reset.
module dmd_hw_bytes #(
   parameter [7:0] HSB_INIT = 8'hff,
   parameter [7:0] SBV_INIT = 8'hff,
   parameter [7:0] SSB_INIT = 8'hff
) (
   // Clock and reset
   input  wire       clk,
   input  wire       reset_n,
   // Programming port
   input  wire       wr_en,
   input  wire [1:0] wr_sel,
   input  wire [7:0] wr_data,
   input  wire       hw_mode,
   input  wire       erase,
   // Stored bytes
   output wire [7:0] hardware_security_byte,
   output wire [7:0] software_boot_vector_byte,
   output wire [7:0] software_security_byte
);

   reg  [7:0] hsb_q;
   reg  [7:0] sbv_q;
   reg  [7:0] ssb_q;
   wire [7:0] hsb_mask;

   // lock bits only in hardware mode
   assign hsb_mask = hw_mode ? (`DMD_HSB_SW_MASK | `DMD_HSB_LOCK_MASK) : `DMD_HSB_SW_MASK;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hsb_q <= HSB_INIT | `DMD_HSB_RSVD_MASK;
         sbv_q <= SBV_INIT;
         ssb_q <= SSB_INIT;
      end else if (erase) begin
         hsb_q <= `DMD_NV_ERASED;
         sbv_q <= `DMD_NV_ERASED;
         ssb_q <= `DMD_NV_ERASED;
      end else if (wr_en) begin
         case (wr_sel)
            2'h0: hsb_q <= (hsb_q & ~hsb_mask) | (wr_data & hsb_mask) | `DMD_HSB_RSVD_MASK;
            2'h1: sbv_q <= wr_data;
            2'h2: ssb_q <= wr_data;
            default: ;
         endcase
      end
   end

   assign hardware_security_byte = hsb_q | `DMD_HSB_RSVD_MASK;
   assign software_boot_vector_byte = sbv_q;
   assign software_security_byte = ssb_q;

endmodule // dmd_hw_bytes

`default_nettype wire

// File: hdl/dmd_decoder.v
// What this block does
// - Lower RAM 00h-7Fh, direct and indirect.
// - Lowest 32 bytes are four 8-register banks.
// - Bank bits offset register numbers into bank.
// - Bit addresses 00h-7Fh hit bytes 20h-2Fh.
// - Indirect 80h-FFh reaches upper RAM.
// - Direct 80h-FFh goes to SPECIAL_FUNCTION_REGISTERS segment.
// - 2 KB expanded RAM via move-external only.
// - Select bit: 0 on-chip, 1 external.
// - Size field limits on-chip expanded RAM.
// - Clock-double bit loads double-speed at reset.
// - Boot-jump bit picks F000h or 0000h vector.
// - Reserved security bits read unprogrammed.
// - Lock bits programmable in hardware mode only.
// - Full erase sets all bytes unprogrammed.
// - Boot vector byte holds entry high address.
// - Software security byte kept for loader.
// - External access: port0 address/data, port2 high.
//
// Design decisions made here: register access over APB and the register addresses.
`include "dmd_regs.vh"
`default_nettype none

module dmd_decoder #(
   parameter [7:0] HSB_INIT = 8'hff,
   parameter [7:0] SBV_INIT = 8'hff,
   parameter [7:0] SSB_INIT = 8'hff
) (
   // Clock and reset
   input  wire        CLK,
   input  wire        RESET_N,
   // APB slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output wire        PREADY,
   output reg  [31:0] PRDATA,
   output wire        PSLVERR,
   // Core access port
   input  wire        CORE_REQ,
   input  wire        CORE_WE,
   input  wire [1:0]  CORE_MODE,
   input  wire [7:0]  CORE_ADDR,
   input  wire        CORE_EXT,
   input  wire        CORE_EXT_RI,
   input  wire [15:0] CORE_XADDR,
   input  wire [7:0]  CORE_WDATA,
   output reg  [7:0]  CORE_RDATA,
   output wire        CORE_ACK,
   // Special function register segment
   output reg         SFR_REQ,
   output reg         SFR_WE,
   output reg  [7:0]  SFR_ADDR,
   output reg  [7:0]  SFR_WDATA,
   input  wire [7:0]  SFR_RDATA,
   // External bus pins
   output reg  [7:0]  P0_OUT,
   output wire        P0_OE,
   input  wire [7:0]  P0_IN,
   output reg  [7:0]  P2_OUT,
   output wire        ALE,
   output wire        RD_N,
   output wire        WR_N,
   // Mode pin and boot outputs
   input  wire        HW_PROG_MODE,
   output reg         DOUBLE_SPEED,
   output reg  [15:0] RESET_VECTOR
);

   // ****************************************************************
   // State and storage
   // ****************************************************************
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_INT   = 3'h1;
   localparam [2:0] ST_SFR   = 3'h2;
   localparam [2:0] ST_XADDR = 3'h3;
   localparam [2:0] ST_XDATA = 3'h4;
   localparam [2:0] ST_XWT1  = 3'h5;
   localparam [2:0] ST_XWT2  = 3'h6;
   localparam [2:0] ST_XDONE = 3'h7;

   reg  [2:0]  state_q;
   reg  [7:0]  ctrl_q;
   reg         boot_pend_q;
   reg         x_we_q;
   reg  [7:0]  x_wdata_q;
   reg  [7:0]  prdata_q;
   reg  [1:0]  hwm_sync_q;
   reg  [7:0]  p0_s1_q;
   reg  [7:0]  p0_s2_q;
   reg  [7:0]  iram [0:255];
   reg  [7:0]  expanded_onchip_ram [0:2047];

   wire [7:0]  hardware_security_byte;
   wire [7:0]  software_boot_vector_byte;
   wire [7:0]  software_security_byte;
   wire        hw_mode;
   wire        apb_wr;
   wire        apb_rd;
   wire        nv_wr;
   wire [1:0]  nv_sel;
   wire        erase;
   wire        mapped;

   // Pin synchronisers; first stages feed only the second stages.
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hwm_sync_q <= 2'h0;
         p0_s1_q    <= 8'h00;
         p0_s2_q    <= 8'h00;
      end else begin
         hwm_sync_q <= {hwm_sync_q[0], HW_PROG_MODE};
         p0_s1_q    <= P0_IN;
         p0_s2_q    <= p0_s1_q;
      end
   end
   assign hw_mode = hwm_sync_q[1];

   // ****************************************************************
   // APB slave
   // ****************************************************************
   assign apb_wr  = PSEL & PENABLE & PWRITE;
   assign apb_rd  = PSEL & ~PENABLE & ~PWRITE;
   assign mapped  = (PADDR == `DMD_OFS_CTRL) | (PADDR == `DMD_OFS_STATUS) |
                    (PADDR == `DMD_OFS_HW_SEC) | (PADDR == `DMD_OFS_BOOT_VEC) |
                    (PADDR == `DMD_OFS_SW_SEC) | (PADDR == `DMD_OFS_CMD);
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped;

   assign nv_wr  = apb_wr & ((PADDR == `DMD_OFS_HW_SEC) | (PADDR == `DMD_OFS_BOOT_VEC) |
                             (PADDR == `DMD_OFS_SW_SEC));
   assign nv_sel = (PADDR == `DMD_OFS_HW_SEC) ? 2'h0 :
                   (PADDR == `DMD_OFS_BOOT_VEC) ? 2'h1 : 2'h2;
   assign erase  = apb_wr & (PADDR == `DMD_OFS_CMD) & PWDATA[`DMD_CMD_ERASE] & hw_mode;

   // Read data is caught in the setup phase so the access phase needs no wait.
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         prdata_q <= 8'h00;
      end else if (apb_rd) begin
         case (PADDR)
            `DMD_OFS_CTRL:     prdata_q <= ctrl_q;
            `DMD_OFS_STATUS:   prdata_q <= {4'h0, (state_q != ST_IDLE), hw_mode,
                                            (RESET_VECTOR == `DMD_VEC_BOOT), DOUBLE_SPEED};
            `DMD_OFS_HW_SEC:   prdata_q <= hardware_security_byte;
            `DMD_OFS_BOOT_VEC: prdata_q <= software_boot_vector_byte;
            `DMD_OFS_SW_SEC:   prdata_q <= software_security_byte;
            default:           prdata_q <= 8'h00;
         endcase
      end
   end

   always @* begin
      PRDATA = {24'h000000, prdata_q};
   end

   dmd_hw_bytes #(
      .HSB_INIT (HSB_INIT),
      .SBV_INIT (SBV_INIT),
      .SSB_INIT (SSB_INIT)
   ) u_hw_bytes (
      .clk     (CLK),
      .reset_n (RESET_N),
      .wr_en   (nv_wr),
      .wr_sel  (nv_sel),
      .wr_data (PWDATA[7:0]),
      .hw_mode (hw_mode),
      .erase   (erase),
      .hardware_security_byte     (hardware_security_byte),
      .software_boot_vector_byte     (software_boot_vector_byte),
      .software_security_byte     (software_security_byte)
   );

   // ****************************************************************
   // Control register and reset-phase loading
   // ****************************************************************
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_q       <= `DMD_CTRL_RESET;
         boot_pend_q  <= 1'b1;
         DOUBLE_SPEED <= 1'b0;
         RESET_VECTOR <= `DMD_VEC_USER;
      end else if (boot_pend_q) begin
         boot_pend_q  <= 1'b0;
         DOUBLE_SPEED <= ~hardware_security_byte[`DMD_HSB_X2B];
         ctrl_q[`DMD_CTRL_X2] <= ~hardware_security_byte[`DMD_HSB_X2B];
         RESET_VECTOR <= hardware_security_byte[`DMD_HSB_BOOT_JUMP_CFG] ? `DMD_VEC_USER : `DMD_VEC_BOOT;
      end else if (apb_wr & (PADDR == `DMD_OFS_CTRL)) begin
         ctrl_q       <= {2'h0, PWDATA[5:0]};
         DOUBLE_SPEED <= PWDATA[`DMD_CTRL_X2];
      end
   end

   // ****************************************************************
   // Address resolution
   // ****************************************************************
   wire [1:0]  bank;
   wire        offchip_sel;
   wire [1:0]  expanded_onchip_ram_size;
   reg  [7:0]  int_addr;
   reg         to_sfr;
   reg  [15:0] x_addr;
   reg  [15:0] expanded_onchip_ram_lim;
   wire        to_expanded_onchip_ram;

   assign bank        = ctrl_q[`DMD_CTRL_BANK_HI:`DMD_CTRL_BANK_LO];
   assign offchip_sel = ctrl_q[`DMD_CTRL_OFFCHIP];
   assign expanded_onchip_ram_size   = ctrl_q[`DMD_CTRL_SIZE_HI:`DMD_CTRL_SIZE_LO];

   always @* begin
      int_addr = CORE_ADDR;
      to_sfr   = 1'b0;
      case (CORE_MODE)
         `DMD_MODE_DIRECT: begin
            // direct below 80h is lower RAM
            // direct upper half is SPECIAL_FUNCTION_REGISTERS space
            to_sfr = (CORE_ADDR > `DMD_LOWER_TOP);
         end
         `DMD_MODE_INDIRECT: begin
            to_sfr = 1'b0;
         end
         `DMD_MODE_REGISTER: begin
            int_addr = {3'h0, bank, CORE_ADDR[2:0]};
         end
         `DMD_MODE_BIT: begin
            if (CORE_ADDR > `DMD_LOWER_TOP) begin
               to_sfr   = 1'b1;
               int_addr = {CORE_ADDR[7:3], 3'h0};
            end else begin
               int_addr = `DMD_BITRAM_BASE | {4'h0, CORE_ADDR[6:3]};
            end
         end
         default: ;
      endcase
   end

   always @* begin
      x_addr = CORE_EXT_RI ? {8'h00, CORE_ADDR} : CORE_XADDR;
      case (expanded_onchip_ram_size)
         2'h0:    expanded_onchip_ram_lim = `DMD_LIM_256;
         2'h1:    expanded_onchip_ram_lim = `DMD_LIM_512;
         2'h2:    expanded_onchip_ram_lim = `DMD_LIM_1K;
         default: expanded_onchip_ram_lim = `DMD_LIM_2K;
      endcase
   end

   // select bit steers to on-chip or external
   assign to_expanded_onchip_ram = ~offchip_sel & (x_addr <= expanded_onchip_ram_lim);

   // ****************************************************************
   // Access sequencer
   // ****************************************************************
   wire [7:0] bit_mask;
   wire [7:0] iram_rd;
   assign bit_mask = 8'h01 << CORE_ADDR[2:0];
   assign iram_rd  = iram[int_addr];

   // arrays have no reset; contents are undefined until written.
   always @(posedge CLK) begin
      if ((state_q == ST_IDLE) & CORE_REQ & CORE_WE) begin
         if (CORE_EXT) begin
            if (to_expanded_onchip_ram) begin
               expanded_onchip_ram[x_addr[10:0]] <= CORE_WDATA;
            end
         end else if (!to_sfr) begin
            if (CORE_MODE == `DMD_MODE_BIT) begin
               iram[int_addr] <= CORE_WDATA[0] ? (iram_rd | bit_mask) : (iram_rd & ~bit_mask);
            end else begin
               iram[int_addr] <= CORE_WDATA;
            end
         end
      end
   end

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q    <= ST_IDLE;
         CORE_RDATA <= 8'h00;
         SFR_REQ    <= 1'b0;
         SFR_WE     <= 1'b0;
         SFR_ADDR   <= 8'h00;
         SFR_WDATA  <= 8'h00;
         P0_OUT     <= 8'h00;
         P2_OUT     <= 8'h00;
         x_we_q     <= 1'b0;
         x_wdata_q  <= 8'h00;
      end else begin
         SFR_REQ <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (CORE_REQ) begin
                  if (CORE_EXT & to_expanded_onchip_ram) begin
                     CORE_RDATA <= expanded_onchip_ram[x_addr[10:0]];
                     state_q    <= ST_INT;
                  end else if (CORE_EXT) begin
                     // low address on port0, high on port2
                     P0_OUT    <= x_addr[7:0];
                     P2_OUT    <= x_addr[15:8];
                     x_we_q    <= CORE_WE;
                     x_wdata_q <= CORE_WDATA;
                     state_q   <= ST_XADDR;
                  end else if (to_sfr) begin
                     SFR_REQ   <= 1'b1;
                     SFR_WE    <= CORE_WE;
                     SFR_ADDR  <= int_addr;
                     SFR_WDATA <= CORE_WDATA;
                     state_q   <= ST_SFR;
                  end else begin
                     CORE_RDATA <= (CORE_MODE == `DMD_MODE_BIT) ?
                                   {7'h00, |(iram_rd & bit_mask)} : iram_rd;
                     state_q    <= ST_INT;
                  end
               end
            end
            ST_SFR: begin
               CORE_RDATA <= SFR_RDATA;
               state_q    <= ST_INT;
            end
            ST_XADDR: begin
               P0_OUT  <= x_wdata_q;
               state_q <= ST_XDATA;
            end
            ST_XDATA: state_q <= ST_XWT1;
            ST_XWT1:  state_q <= ST_XWT2;
            ST_XWT2: begin
               CORE_RDATA <= x_we_q ? CORE_RDATA : p0_s2_q;
               state_q    <= ST_XDONE;
            end
            ST_INT:   state_q <= ST_IDLE;
            ST_XDONE: state_q <= ST_IDLE;
            default:  state_q <= ST_IDLE;
         endcase
      end
   end

   // Strobes span data and both wait cycles, so a read is sampled after the synchroniser settles.
   assign CORE_ACK = (state_q == ST_INT) | (state_q == ST_XDONE);
   assign ALE      = (state_q == ST_XADDR);
   assign P0_OE    = (state_q == ST_XADDR) |
                     (x_we_q & ((state_q == ST_XDATA) | (state_q == ST_XWT1) | (state_q == ST_XWT2)));
   assign RD_N     = ~(~x_we_q & ((state_q == ST_XDATA) | (state_q == ST_XWT1) | (state_q == ST_XWT2)));
   assign WR_N     = ~(x_we_q & ((state_q == ST_XDATA) | (state_q == ST_XWT1) | (state_q == ST_XWT2)));

endmodule // dmd_decoder

`default_nettype wire

// File: verif/dmd_decoder_properties.sv
`include "dmd_regs.vh"
`default_nettype none
module dmd_decoder_properties #(
   parameter logic [7:0] HSB_INIT = 8'hff
) (
   // Clock and reset
   input wire logic        CLK,
   input wire logic        RESET_N,
   // Core port
   input wire logic        CORE_REQ,
   input wire logic        CORE_WE,
   input wire logic [1:0]  CORE_MODE,
   input wire logic [7:0]  CORE_ADDR,
   input wire logic        CORE_EXT,
   input wire logic        CORE_EXT_RI,
   input wire logic [15:0] CORE_XADDR,
   input wire logic        CORE_ACK,
   // Segments and pins
   input wire logic        SFR_REQ,
   input wire logic [7:0]  SFR_ADDR,
   input wire logic [7:0]  P0_OUT,
   input wire logic        P0_OE,
   input wire logic [7:0]  P2_OUT,
   input wire logic        ALE,
   input wire logic        RD_N,
   input wire logic        WR_N,
   input wire logic        DOUBLE_SPEED,
   input wire logic [15:0] RESET_VECTOR
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dmd_cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   logic req_q;
   wire  new_int = CORE_REQ && !req_q && !CORE_EXT;
   wire  new_ext = CORE_REQ && !req_q && CORE_EXT;

   // The bench drops its request after every answer, so a rise marks a new access.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         req_q <= 1'b0;
      end else begin
         req_q <= CORE_REQ;
      end
   end

   AST_LOWER: assert property (new_int && CORE_MODE == `DMD_MODE_DIRECT && !CORE_ADDR[7] |=> CORE_ACK && !SFR_REQ)
      else $error("direct low access left the internal RAM");
   AST_REG_BANK: assert property (new_int && CORE_MODE == `DMD_MODE_REGISTER |=> CORE_ACK && !SFR_REQ)
      else $error("register access left the internal RAM");
   AST_BIT_AREA: assert property (new_int && CORE_MODE == `DMD_MODE_BIT && !CORE_ADDR[7] |=> CORE_ACK && !SFR_REQ)
      else $error("low bit access left the internal RAM");
   AST_UPPER: assert property (new_int && CORE_MODE == `DMD_MODE_INDIRECT |=> CORE_ACK && !SFR_REQ)
      else $error("indirect access went to the register segment");
   AST_SFR: assert property (new_int && CORE_MODE == `DMD_MODE_DIRECT && CORE_ADDR[7]
      |=> SFR_REQ && SFR_ADDR == $past(CORE_ADDR) ##1 CORE_ACK)
      else $error("direct high access not sent to the register segment");
   AST_EXT_ADDR: assert property (new_ext && !CORE_EXT_RI ##1 ALE
      |-> P0_OE && P0_OUT == $past(CORE_XADDR[7:0]) && P2_OUT == $past(CORE_XADDR[15:8]))
      else $error("external address phase wrong");
   AST_EXT_RI: assert property (new_ext && CORE_EXT_RI ##1 ALE |-> P2_OUT == 8'h00 && P0_OUT == $past(CORE_ADDR))
      else $error("register-relative external address wrong");
   AST_EXT_WR: assert property (ALE && CORE_WE |=> (!WR_N && RD_N && P0_OE) [*3] ##1 CORE_ACK)
      else $error("external write strobe wrong");
   AST_EXT_RD: assert property (ALE && !CORE_WE |=> (!RD_N && WR_N && !P0_OE) [*3] ##1 CORE_ACK)
      else $error("external read strobe wrong");
   AST_X2_LOAD: assert property ($past(RESET_N) && !$past(RESET_N, 2) |-> DOUBLE_SPEED == !HSB_INIT[7])
      else $error("double speed not loaded at reset");
   AST_VEC_LOAD: assert property ($past(RESET_N) && !$past(RESET_N, 2)
      |-> RESET_VECTOR == (HSB_INIT[6] ? 16'h0000 : 16'hf000))
      else $error("reset vector not selected at reset");
   AST_VEC_HOLD: assert property ($past(RESET_N, 2) |-> $stable(RESET_VECTOR))
      else $error("reset vector changed outside reset");

   cover property (new_ext ##1 ALE);
   cover property (SFR_REQ ##1 CORE_ACK);
   cover property (new_int && CORE_MODE == `DMD_MODE_BIT);
endmodule // dmd_decoder_properties
`default_nettype wire

// File: verif/dmd_partner_model.sv
`default_nettype none
module dmd_partner_model (
   // Clock
   input  wire logic       clk,
   // Register segment
   input  wire logic       sfr_req,
   input  wire logic       sfr_we,
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   output var  logic [7:0] sfr_rdata,
   // External bus
   input  wire logic [7:0] p0_out,
   input  wire logic       p0_oe,
   input  wire logic [7:0] p2_out,
   input  wire logic       ale,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   output var  logic [7:0] p0_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  sfr_q [256];
   logic [7:0]  offchip_ram_q [65536];
   logic [15:0] addr_q = 16'h0000;
   logic [7:0]  last_q = 8'h00;
   logic        sel_q = 1'b0;

   always @(posedge clk) begin
      sel_q <= sfr_req;
      last_q <= p0_in;
      if (ale) addr_q <= {p2_out, p0_out};
      if (!wr_n) offchip_ram_q[addr_q] <= p0_out;
      if (sfr_req && sfr_we) sfr_q[sfr_addr] <= sfr_wdata;
   end
   // A released bus shows inverted data (port0 toggles each cycle, the register segment reads the complement), never the last value.
   assign sfr_rdata = (sfr_req || sel_q) ? sfr_q[sfr_addr] : ~sfr_q[sfr_addr];
   assign p0_in = p0_oe ? p0_out : (!rd_n ? offchip_ram_q[addr_q] : ~last_q);
endmodule // dmd_partner_model
`default_nettype wire

// File: verif/dmd_decoder_tb.sv
`include "dmd_regs.vh"
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module dmd_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] HSB_INIT = 8'h05;
   localparam logic [1:0] DIR = `DMD_MODE_DIRECT, IND = `DMD_MODE_INDIRECT, REG = `DMD_MODE_REGISTER, BIT = `DMD_MODE_BIT;
   logic CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, HW_PROG_MODE = 0;
   logic [7:0] PADDR = 0, CORE_ADDR = 0, CORE_WDATA = 0, CORE_RDATA, SFR_ADDR, SFR_WDATA, SFR_RDATA;
   logic [31:0] PWDATA = 0, PRDATA, rd;
   logic CORE_REQ = 0, CORE_WE = 0, CORE_EXT = 0, CORE_EXT_RI = 0, CORE_ACK, SFR_REQ, SFR_WE;
   logic [1:0] CORE_MODE = 0;
   logic [15:0] CORE_XADDR = 0, RESET_VECTOR;
   logic [7:0] P0_OUT, P0_IN, P2_OUT, rd8, v, w, a;
   logic P0_OE, ALE, RD_N, WR_N, DOUBLE_SPEED, er;
   int errors = 0, num_checks = 0, cyc = 0, lim, r;

   dmd_decoder #(.HSB_INIT(HSB_INIT)) dmd_decoder_i (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
      .PREADY, .PRDATA, .PSLVERR, .CORE_REQ, .CORE_WE, .CORE_MODE, .CORE_ADDR, .CORE_EXT, .CORE_EXT_RI,
      .CORE_XADDR, .CORE_WDATA, .CORE_RDATA, .CORE_ACK, .SFR_REQ, .SFR_WE, .SFR_ADDR, .SFR_WDATA, .SFR_RDATA,
      .P0_OUT, .P0_OE, .P0_IN, .P2_OUT, .ALE, .RD_N, .WR_N, .HW_PROG_MODE, .DOUBLE_SPEED, .RESET_VECTOR);
   dmd_partner_model dmd_partner_model_i (.clk(CLK), .sfr_req(SFR_REQ), .sfr_we(SFR_WE), .sfr_addr(SFR_ADDR),
      .sfr_wdata(SFR_WDATA), .sfr_rdata(SFR_RDATA), .p0_out(P0_OUT), .p0_oe(P0_OE), .p2_out(P2_OUT),
      .ale(ALE), .rd_n(RD_N), .wr_n(WR_N), .p0_in(P0_IN));

   always #4 CLK = ~CLK;

   // ****************************************************************
   // Bus tasks
   // ****************************************************************
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= ad;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic core(input logic we, input logic [1:0] md, input logic [7:0] ad, input logic ex, input logic ri,
                       input logic [15:0] xa, input logic [7:0] wd);
      @(posedge CLK);
      CORE_REQ <= 1'b1;
      CORE_WE <= we;
      CORE_MODE <= md;
      CORE_ADDR <= ad;
      CORE_EXT <= ex;
      CORE_EXT_RI <= ri;
      CORE_XADDR <= xa;
      CORE_WDATA <= wd;
      do @(posedge CLK); while (CORE_ACK !== 1'b1);
      rd8 = CORE_RDATA;
      CORE_REQ <= 1'b0;
   endtask

   task automatic mem(input logic we, input logic [1:0] md, input logic [7:0] ad, input logic [7:0] wd);
      core(we, md, ad, 1'b0, 1'b0, 16'h0000, wd);
   endtask

   task automatic xmem(input logic we, input logic ri, input logic [15:0] xa, input logic [7:0] wd);
      core(we, DIR, xa[7:0], 1'b1, ri, xa, wd);
   endtask

   task final_report;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         final_report();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      void'($urandom(96));
      repeat (6) @(posedge CLK);
      RESET_N <= 1'b1;
      repeat (2) @(negedge CLK);
      `CHK(DOUBLE_SPEED, 1'b1)
      `CHK(RESET_VECTOR, 16'hf000)
      apb(1'b0, `DMD_OFS_CTRL, 32'h0);
      `CHK(rd, 32'h20)
      apb(1'b0, `DMD_OFS_STATUS, 32'h0);
      `CHK(rd, 32'h03)
      apb(1'b0, `DMD_OFS_HW_SEC, 32'h0);
      `CHK(rd, 32'h3d)
      apb(1'b0, 8'h18, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      for (int i = 0; i < 2; i++) begin
         v = 8'($urandom);
         apb(1'b1, 8'(`DMD_OFS_BOOT_VEC + 4 * i), 32'(v));
         apb(1'b0, 8'(`DMD_OFS_BOOT_VEC + 4 * i), 32'h0);
         `CHK(rd, 32'(v))
      end
      apb(1'b1, `DMD_OFS_HW_SEC, 32'h38);
      apb(1'b1, `DMD_OFS_CMD, 32'h1);
      apb(1'b0, `DMD_OFS_HW_SEC, 32'h0);
      `CHK(rd, 32'h3d)
      HW_PROG_MODE <= 1'b1;
      repeat (3) @(posedge CLK);
      apb(1'b1, `DMD_OFS_HW_SEC, 32'h3a);
      apb(1'b0, `DMD_OFS_HW_SEC, 32'h0);
      `CHK(rd, 32'h3a)
      apb(1'b0, `DMD_OFS_STATUS, 32'h0);
      `CHK(rd, 32'h07)
      apb(1'b1, `DMD_OFS_CMD, 32'h1);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 8'(`DMD_OFS_HW_SEC + 4 * i), 32'h0);
         `CHK(rd, 32'hff)
      end
      HW_PROG_MODE <= 1'b0;
      // every location is written before it is read
      for (int b = 0; b < 4; b++) begin
         r = $urandom_range(7);
         v = 8'($urandom);
         apb(1'b1, `DMD_OFS_CTRL, 32'(b));
         mem(1'b1, REG, 8'(r), v);
         mem(1'b0, DIR, 8'(b * 8 + r), 8'h00);
         `CHK(rd8, v)
      end
      v = 8'($urandom);
      mem(1'b1, DIR, 8'h7f, v);
      mem(1'b0, IND, 8'h7f, 8'h00);
      `CHK(rd8, v)
      a = 8'(8'h80 + $urandom_range(127));
      mem(1'b1, IND, a, v);
      mem(1'b1, DIR, a, ~v);
      mem(1'b0, IND, a, 8'h00);
      `CHK(rd8, v)
      mem(1'b0, DIR, a, 8'h00);
      `CHK(rd8, ~v)
      r = $urandom_range(127);
      mem(1'b1, DIR, 8'(8'h20 + r / 8), 8'h00);
      mem(1'b1, BIT, 8'(r), 8'h01);
      mem(1'b0, DIR, 8'(8'h20 + r / 8), 8'h00);
      `CHK(rd8, 8'(1 << (r % 8)))
      mem(1'b0, BIT, 8'(r), 8'h00);
      `CHK(rd8[0], 1'b1)
      // Same address written with select bit 0 then 1 tells which copy a read reaches.
      for (int s = 0; s < 4; s++) begin
         lim = (256 << s) - 1;
         for (int k = 0; k < 2; k++) begin
            v = 8'($urandom);
            w = ~v;
            apb(1'b1, `DMD_OFS_CTRL, 32'(s << 3));
            xmem(1'b1, 1'b0, 16'(lim + k), v);
            apb(1'b1, `DMD_OFS_CTRL, 32'(s << 3 | 4));
            xmem(1'b1, 1'b0, 16'(lim + k), w);
            xmem(1'b0, 1'b0, 16'(lim + k), 8'h00);
            `CHK(rd8, w)
            apb(1'b1, `DMD_OFS_CTRL, 32'(s << 3));
            xmem(1'b0, 1'b0, 16'(lim + k), 8'h00);
            `CHK(rd8, (k == 0) ? v : w)
         end
      end
      apb(1'b1, `DMD_OFS_CTRL, 32'h0);
      core(1'b1, DIR, 8'h10, 1'b1, 1'b1, 16'h7f10, v);
      xmem(1'b0, 1'b0, 16'h0010, 8'h00);
      `CHK(rd8, v)
      apb(1'b1, `DMD_OFS_CTRL, 32'h4);
      core(1'b1, DIR, 8'h20, 1'b1, 1'b1, 16'h5a20, w);
      xmem(1'b0, 1'b0, 16'h0020, 8'h00);
      `CHK(rd8, w)
      final_report();
   end
endmodule // dmd_decoder_tb
bind dmd_decoder dmd_decoder_properties #(.HSB_INIT(HSB_INIT)) dmd_decoder_properties_i (.CLK, .RESET_N,
   .CORE_REQ, .CORE_WE, .CORE_MODE, .CORE_ADDR, .CORE_EXT, .CORE_EXT_RI, .CORE_XADDR, .CORE_ACK, .SFR_REQ,
   .SFR_ADDR, .P0_OUT, .P0_OE, .P2_OUT, .ALE, .RD_N, .WR_N, .DOUBLE_SPEED, .RESET_VECTOR);
`default_nettype wire
